// file: hw/bscu_pkg.sv
// package: constants and types for the branch and skip condition unit
package bscu_pkg;
  localparam int unsigned PC_W         = 16;
  localparam int unsigned OFS_W        = 7;
  localparam int unsigned BIT_SEL_W    = 3;
  localparam int unsigned FLAG_C       = 0;
  localparam int unsigned FLAG_Z       = 1;
  localparam int unsigned FLAG_N       = 2;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_W-1:0] STEP_ONE = 16'h0001;
  localparam logic [PC_W-1:0] STEP_TWO = 16'h0002;
  localparam logic [PC_W-1:0] STEP_THR = 16'h0003;
  localparam logic [1:0] CYC_ONE       = 2'h1;
  localparam logic [1:0] CYC_NONE      = 2'h0;
  localparam logic [1:0] CYC_TWO       = 2'h2;
  localparam logic [7:0] FLAGS_RESET   = 8'h00;

  typedef enum logic [3:0] {
    BSCU_OP_NONE       = 4'h0,
    BSCU_OP_SKIP_REG   = 4'h1,
    BSCU_OP_SKIP_IOCLR = 4'h2,
    BSCU_OP_SKIP_IOSET = 4'h3,
    BSCU_OP_BR_SET     = 4'h4,
    BSCU_OP_BR_CLR     = 4'h5,
    BSCU_OP_BR_EQ      = 4'h6,
    BSCU_OP_BR_NE      = 4'h7,
    BSCU_OP_BR_CS      = 4'h8,
    BSCU_OP_BR_CC      = 4'h9,
    BSCU_OP_BR_SH      = 4'hA,
    BSCU_OP_BR_LO      = 4'hB,
    BSCU_OP_BR_MI      = 4'hC,
    BSCU_OP_BR_PL      = 4'hD
  } bscu_op_t;

  typedef enum logic [2:0] {
    BSCU_ST_IDLE  = 3'b001,
    BSCU_ST_EXTRA = 3'b010,
    BSCU_ST_DONE  = 3'b100
  } bscu_state_t;
endpackage

// file: hw/bscu_cond_if.sv
// interface: condition request and verdict between evaluator and sequencer
`timescale 1ns/10ps
interface bscu_cond_if;
  logic                          valid;
  bscu_pkg::bscu_op_t            op;
  logic [7:0]                    operand;
  logic [bscu_pkg::BIT_SEL_W-1:0] bit_sel;
  logic [7:0]                    status_flags_reg;
  logic                          taken;
  logic                          is_skip;
  modport src (output valid, op, operand, bit_sel, status_flags_reg);
  modport eval (input valid, op, operand, bit_sel, status_flags_reg, output taken, is_skip);
  modport sink (input valid, op, taken, is_skip);
endinterface

// file: hw/bscu_cond_eval.sv
// module: combinational condition test for skips and branches
`timescale 1ns/10ps
module bscu_cond_eval (
  // condition channel
  bscu_cond_if.eval c
);
  logic sel_bit;
  logic st_bit;
  assign sel_bit = c.operand[c.bit_sel];
  assign st_bit  = c.status_flags_reg[c.bit_sel];

  always_comb begin
    c.taken   = 1'b0;
    c.is_skip = 1'b0;
    case (c.op)
      bscu_pkg::BSCU_OP_SKIP_REG: begin
        c.is_skip = 1'b1;
        c.taken   = sel_bit;
      end
      bscu_pkg::BSCU_OP_SKIP_IOCLR: begin
        c.is_skip = 1'b1;
        c.taken   = ~sel_bit;
      end
      bscu_pkg::BSCU_OP_SKIP_IOSET: begin
        c.is_skip = 1'b1;
        c.taken   = sel_bit;
      end
      bscu_pkg::BSCU_OP_BR_SET: c.taken = st_bit;
      bscu_pkg::BSCU_OP_BR_CLR: c.taken = ~st_bit;
      bscu_pkg::BSCU_OP_BR_EQ:  c.taken = c.status_flags_reg[bscu_pkg::FLAG_Z];
      bscu_pkg::BSCU_OP_BR_NE:  c.taken = ~c.status_flags_reg[bscu_pkg::FLAG_Z];
      bscu_pkg::BSCU_OP_BR_CS:  c.taken = c.status_flags_reg[bscu_pkg::FLAG_C];
      bscu_pkg::BSCU_OP_BR_CC:  c.taken = ~c.status_flags_reg[bscu_pkg::FLAG_C];
      bscu_pkg::BSCU_OP_BR_SH:  c.taken = ~c.status_flags_reg[bscu_pkg::FLAG_C];
      bscu_pkg::BSCU_OP_BR_LO:  c.taken = c.status_flags_reg[bscu_pkg::FLAG_C];
      bscu_pkg::BSCU_OP_BR_MI:  c.taken = c.status_flags_reg[bscu_pkg::FLAG_N];
      bscu_pkg::BSCU_OP_BR_PL:  c.taken = ~c.status_flags_reg[bscu_pkg::FLAG_N];
      default: begin
        c.taken   = 1'b0;
        c.is_skip = 1'b0;
      end
    endcase
    // no verdict without an accepted issue
    if (!c.valid) begin
      c.taken = 1'b0;
    end
  end
endmodule

// file: hw/bscu_core.sv
// module: branch and skip condition unit, program counter update and stall
// Behaviour
// - register bit set skips next instruction
// - io bit clear skips next instruction
// - io bit set skips next instruction
// - selected status bit set branches
// - selected status bit clear branches
// - zero flag set branches
// - zero flag clear branches
// - carry flag set branches
// - carry flag clear branches
// - same or higher equals carry clear
// - lower equals carry set
// - negative flag set branches
// - negative flag clear branches
// - status flags never modified here
`timescale 1ns/10ps
module bscu_core (
  // clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  // instruction issue
  input  wire logic                           issue_valid,
  input  wire bscu_pkg::bscu_op_t             issue_op,
  input  wire logic [7:0]                     operand,
  input  wire logic [bscu_pkg::BIT_SEL_W-1:0] bit_sel,
  input  wire logic [bscu_pkg::OFS_W-1:0]     branch_offset,
  input  wire logic                           next_is_two_word,
  input  wire logic [7:0]                     status_flags_in,
  // results
  output logic [bscu_pkg::PC_W-1:0]           program_counter,
  output logic                                busy,
  output logic                                done,
  output logic                                taken,
  output logic [7:0]                          status_flags_out
);
  bscu_cond_if cif ();

  bscu_pkg::bscu_state_t state_q;
  logic [bscu_pkg::PC_W-1:0] pc_q;
  logic [bscu_pkg::PC_W-1:0] pc_d;
  logic [1:0]                extra_q;
  logic [1:0]                extra_d;
  logic                      busy_q;
  logic                      done_q;
  logic                      taken_q;
  logic [7:0]                flags_q;
  logic                      accept;
  logic [bscu_pkg::PC_W-1:0] ofs_ext;

  assign accept                = issue_valid && (state_q == bscu_pkg::BSCU_ST_IDLE);
  assign cif.valid             = accept;
  assign cif.op                = issue_op;
  assign cif.operand           = operand;
  assign cif.bit_sel           = bit_sel;
  assign cif.status_flags_reg  = status_flags_in;

  bscu_cond_eval u_eval (
    .c (cif.eval)
  );

  // sign extend the word offset
  assign ofs_ext = {{(bscu_pkg::PC_W-bscu_pkg::OFS_W){branch_offset[bscu_pkg::OFS_W-1]}},
                    branch_offset};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    pc_d    = pc_q + bscu_pkg::STEP_ONE;
    extra_d = bscu_pkg::CYC_NONE;
    if (cif.taken) begin
      if (cif.is_skip) begin
        // skipped word count sets both step and extra cycles
        if (next_is_two_word) begin
          pc_d    = pc_q + bscu_pkg::STEP_THR;
          extra_d = bscu_pkg::CYC_TWO;
        end else begin
          pc_d    = pc_q + bscu_pkg::STEP_TWO;
          extra_d = bscu_pkg::CYC_ONE;
        end
      end else begin
        pc_d    = pc_q + ofs_ext + bscu_pkg::STEP_ONE;
        extra_d = bscu_pkg::CYC_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_q <= bscu_pkg::PC_RESET;
    end else if (accept) begin
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= bscu_pkg::BSCU_ST_IDLE;
      extra_q <= bscu_pkg::CYC_NONE;
    end else begin
      case (state_q)
        bscu_pkg::BSCU_ST_IDLE: begin
          if (accept) begin
            if (extra_d != bscu_pkg::CYC_NONE) begin
              state_q <= bscu_pkg::BSCU_ST_EXTRA;
              extra_q <= extra_d;
            end else begin
              state_q <= bscu_pkg::BSCU_ST_DONE;
            end
          end
        end
        bscu_pkg::BSCU_ST_EXTRA: begin
          extra_q <= extra_q - bscu_pkg::CYC_ONE;
          if (extra_q == bscu_pkg::CYC_ONE) begin
            state_q <= bscu_pkg::BSCU_ST_DONE;
          end
        end
        bscu_pkg::BSCU_ST_DONE: begin
          state_q <= bscu_pkg::BSCU_ST_IDLE;
        end
        default: begin
          state_q <= bscu_pkg::BSCU_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      taken_q <= 1'b0;
    end else if (accept) begin
      taken_q <= cif.taken;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= accept || (state_q == bscu_pkg::BSCU_ST_EXTRA && extra_q != bscu_pkg::CYC_ONE);
      done_q <= (accept && extra_d == bscu_pkg::CYC_NONE) ||
                (state_q == bscu_pkg::BSCU_ST_EXTRA && extra_q == bscu_pkg::CYC_ONE);
    end
  end

  // flags pass through untouched
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_q <= bscu_pkg::FLAGS_RESET;
    end else begin
      flags_q <= status_flags_in;
    end
  end

  assign program_counter  = pc_q;
  assign busy             = busy_q;
  assign done             = done_q;
  assign taken            = taken_q;
  assign status_flags_out = flags_q;
endmodule

// file: verification/bscu_core_checker.sv
// checker: port-level properties of the branch and skip unit
`timescale 1ns/10ps
module bscu_core_checker (
  // clock, reset and issue
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               issue_valid,
  input wire bscu_pkg::bscu_op_t issue_op,
  input wire logic [7:0]         operand,
  input wire logic [2:0]         bit_sel,
  input wire logic [6:0]         branch_offset,
  input wire logic               next_is_two_word,
  input wire logic [7:0]         status_flags_in,
  // results
  input wire logic [15:0]        program_counter,
  input wire logic               busy,
  input wire logic               done,
  input wire logic               taken,
  input wire logic [7:0]         status_flags_out
);
  logic        acc;
  logic [15:0] tgt;
  assign acc = issue_valid && !busy && !done;
  assign tgt = program_counter + {{9{branch_offset[6]}}, branch_offset} + 16'h0001;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  a_flags_untouched: assert property (
    !$past(rst) |-> status_flags_out == $past(status_flags_in))
    else $error("flags altered");
  a_done_single: assert property (done |=> !done)
    else $error("done too long");
  a_fall_through: assert property (
    acc ##1 !taken |-> done && program_counter == $past(program_counter) + 16'h0001)
    else $error("bad fall through");
  a_equal_jump: assert property (
    acc && issue_op == bscu_pkg::BSCU_OP_BR_EQ && status_flags_in[1]
    |=> taken && program_counter == $past(tgt))
    else $error("bad equal jump");
  a_not_equal: assert property (
    acc && issue_op == bscu_pkg::BSCU_OP_BR_NE |=> taken == !$past(status_flags_in[1]))
    else $error("bad not equal");
  a_carry_set: assert property (
    acc && issue_op inside {bscu_pkg::BSCU_OP_BR_CS, bscu_pkg::BSCU_OP_BR_LO}
    |=> taken == $past(status_flags_in[0]))
    else $error("bad carry set");
  a_carry_clear: assert property (
    acc && issue_op inside {bscu_pkg::BSCU_OP_BR_CC, bscu_pkg::BSCU_OP_BR_SH}
    |=> taken == !$past(status_flags_in[0]))
    else $error("bad carry clear");
  a_minus_jump: assert property (
    acc && issue_op == bscu_pkg::BSCU_OP_BR_MI |=> taken == $past(status_flags_in[2]))
    else $error("bad minus");
  a_plus_jump: assert property (
    acc && issue_op == bscu_pkg::BSCU_OP_BR_PL |=> taken == !$past(status_flags_in[2]))
    else $error("bad plus");
  a_long_skip: assert property (
    acc && issue_op == bscu_pkg::BSCU_OP_SKIP_IOSET && operand[bit_sel] && next_is_two_word
    |=> busy[*2] ##1 done)
    else $error("bad long skip");
  c_equal: cover property (acc && issue_op == bscu_pkg::BSCU_OP_BR_EQ);
  c_taken: cover property (acc ##1 taken);
  c_long: cover property (busy[*2]);
endmodule
bind bscu_core bscu_core_checker bscu_core_checker_i (.core_clk, .rst, .issue_valid, .issue_op,
  .operand, .bit_sel, .branch_offset, .next_is_two_word, .status_flags_in, .program_counter,
  .busy, .done, .taken, .status_flags_out);

// file: verification/bscu_core_tb_top.sv
// testbench: directed runs of the branch and skip unit
`timescale 1ns/10ps
module bscu_core_tb_top;
  logic               core_clk, rst, issue_valid, two, busy, done, taken;
  bscu_pkg::bscu_op_t op;
  logic [7:0]         opnd, flags, fo;
  logic [6:0]         k;
  logic [2:0]         bs;
  logic [15:0]        pc, epc;
  int                 n_mismatch = 0;
  int                 samples_checked = 0;
  bscu_core bscu_core_i (.core_clk, .rst, .issue_valid, .issue_op(op), .operand(opnd),
    .bit_sel(bs), .branch_offset(k), .next_is_two_word(two), .status_flags_in(flags),
    .program_counter(pc), .busy, .done, .taken, .status_flags_out(fo));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // one op: offer for one cycle, wait for done, judge pc, outcome, latency, flags
  task automatic run(logic [3:0] o, logic [7:0] v, logic [2:0] b, logic [6:0] off, logic tw,
      logic [7:0] f, logic et);
    int n;
    logic sk;
    n = 0;
    sk = o inside {4'h1, 4'h2, 4'h3};
    @(negedge core_clk);
    op = bscu_pkg::bscu_op_t'(o);
    opnd = v;
    bs = b;
    k = off;
    two = tw;
    flags = f;
    issue_valid = 1'b1;
    @(negedge core_clk);
    issue_valid = 1'b0;
    while (done !== 1'b1 && n < 5) begin
      @(negedge core_clk);
      n++;
    end
    if (et) epc += sk ? (tw ? 16'h0003 : 16'h0002) : {{9{off[6]}}, off} + 16'h0001;
    else epc += 16'h0001;
    chk(pc, epc);
    chk({15'h0000, taken}, {15'h0000, et});
    chk(16'(n), et ? ((sk && tw) ? 16'h0002 : 16'h0001) : 16'h0000);
    chk({8'h00, fo}, {8'h00, f});
  endtask
  task automatic t_skips;
    logic [7:0] m;
    logic       e;
    for (int b = 0; b < 8; b++) begin
      for (int j = 0; j < 6; j++) begin
        m = j[0] ? ~(8'h01 << b) : 8'h01 << b;
        e = (j / 2 == 1) == j[0];
        run(4'(1 + j / 2), m, b[2:0], 7'h00, b[0], 8'hA5, e);
      end
    end
  endtask
  task automatic t_flag_br;
    logic [7:0] m;
    for (int s = 0; s < 8; s++) begin
      for (int j = 0; j < 4; j++) begin
        m = j[0] ? ~(8'h01 << s) : 8'h01 << s;
        run(4'(4 + j / 2), 8'h00, s[2:0], 7'h7E, 1'b0, m, j[1] == j[0]);
      end
    end
  endtask
  task automatic t_named;
    logic [1:0] fb [8] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
    logic       pl [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [7:0] f;
    logic       e;
    for (int i = 0; i < 16; i++) begin
      f = i[0] ? 8'hFF : 8'h00;
      e = f[fb[i/2]] == pl[i/2];
      run(4'(6 + i / 2), 8'h00, 3'h0, {i[1], 6'h15}, 1'b0, f, e);
    end
  endtask
  initial begin
    {rst, issue_valid, two} = 3'h4;
    {opnd, flags, k, bs} = 26'h0000000;
    op = bscu_pkg::BSCU_OP_NONE;
    epc = 16'h0000;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    chk(pc, bscu_pkg::PC_RESET);
    run(4'h0, 8'hFF, 3'h7, 7'h10, 1'b1, 8'hFF, 1'b0);
    t_skips;
    t_flag_br;
    t_named;
    end_sim;
  end
  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end
endmodule
